/* sdr_pkg.sv */
/*
 * Shared constants and carrier types for the spike detector and sense readout block.
 * Assumes an 8-bit register port driven by an SMBus slave elsewhere in the unit.
 */
package sdr_pkg;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] SDR_SPIKE_CFG_ADDR   = 8'h52;
    localparam logic [7:0] SDR_SENSE_HI_ADDR    = 8'h54;
    localparam logic [7:0] SDR_SENSE_LO_ADDR    = 8'h55;
    localparam logic [7:0] SDR_SUPPLY_HI_ADDR   = 8'h58;
    localparam logic [7:0] SDR_SUPPLY_LO_ADDR   = 8'h59;

    // ------------------------------------------------------------------
    // Reset values and field positions
    // ------------------------------------------------------------------
    localparam logic [7:0] SDR_CFG_RESET        = 8'h00;
    localparam logic [7:0] SDR_RESULT_RESET     = 8'h00;
    localparam int         SDR_TH_LSB           = 4;
    localparam int         SDR_DUR_LSB          = 0;
    localparam logic [1:0] SDR_RANGE_RESET      = 2'h3;
    localparam logic       SDR_ROUTE_RESET      = 1'b1;

    // ------------------------------------------------------------------
    // Threshold: 10 mV plus 5 mV per code step, in microvolts
    // ------------------------------------------------------------------
    localparam int         SDR_TH_BASE_UV       = 10000;
    localparam int         SDR_TH_STEP_UV       = 5000;
    // Full scale for range code 0, doubling for each step, in microvolts.
    localparam int         SDR_FS_BASE_UV       = 10000;
    localparam int         SDR_SENSE_FS_CODE    = 2047;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int         SDR_CLK_MHZ          = 100;
    localparam int         SDR_TICK_NS          = 10240;
    localparam int         SDR_TICK_CYCLES      = (SDR_TICK_NS * SDR_CLK_MHZ) / 1000;
    localparam int         SDR_ONE_MS_NS        = 1000000;
    localparam int         SDR_ONE_MS_CYCLES    = (SDR_ONE_MS_NS * SDR_CLK_MHZ) / 1000;

    // Register port request.
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } sdr_req_t;

    // One measurement update from the front end.
    typedef struct packed {
        logic        sense_valid;
        logic [11:0] sense_code;
        logic        supply_valid;
        logic [11:0] supply_code;
    } sdr_meas_t;

    typedef enum logic [2:0] {
        SDR_IDLE  = 3'b001,
        SDR_TIME  = 3'b010,
        SDR_FIRED = 3'b100
    } sdr_state_t;

endpackage : sdr_pkg

/* sdr_spike_readout.sv */
/*
 * Spike detector configuration, detector and measurement result registers.
 * Assumes an SMBus slave presents one-cycle read and write strobes with an 8-bit
 * address, and that the front end delivers signed sense and signed supply codes.
 */
`timescale 1ns/1ps
module sdr_spike_readout
    import sdr_pkg::*;
#(
    parameter int TICK_CYCLES = SDR_TICK_CYCLES,
    parameter int MS_CYCLES   = SDR_ONE_MS_CYCLES
)
(
    input  wire logic       clk,
    input  wire logic       rstn,
    input  wire sdr_req_t   req,
    output logic [7:0]      rdata,
    output logic            rvalid,
    input  wire logic [3:0] threshold_strap_pin,
    input  wire logic [3:0] duration_strap_pin,
    input  wire logic [1:0] shunt_full_scale_sel,
    input  wire logic       spike_output_route,
    input  wire sdr_meas_t  meas,
    input  wire logic [11:0] shunt_voltage_live,
    output logic            spike_alert_out,
    output logic            critical_alarm_out
);

    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    logic [7:0]  spike_detect_config_reg;
    logic        strap_loaded_reg;
    logic [11:0] shunt_voltage_reg;
    logic [10:0] supply_voltage_reg;
    sdr_state_t  state_reg;
    logic [31:0] tick_cnt_reg;
    logic [31:0] tick_total_reg;
    logic [31:0] ms_cnt_reg;
    logic        ms_done_reg;

    logic [3:0]  spike_threshold_code;
    logic [3:0]  spike_duration_code;
    logic [11:0] magnitude;
    logic [31:0] thresh_code;
    logic        above;
    logic [31:0] dur_ticks;

    assign spike_threshold_code = spike_detect_config_reg[SDR_TH_LSB +: 4];
    assign spike_duration_code  = spike_detect_config_reg[SDR_DUR_LSB +: 4];

    // ------------------------------------------------------------------
    // Configuration register
    // ------------------------------------------------------------------
    // Reset takes the constant, the first clock after release loads the straps unless a config write comes in that cycle.
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            spike_detect_config_reg <= SDR_CFG_RESET;
            strap_loaded_reg        <= 1'b0;
        end
        else if (req.wr && req.addr == SDR_SPIKE_CFG_ADDR)
        begin
            spike_detect_config_reg <= req.wdata;
            strap_loaded_reg        <= 1'b1;
        end
        else if (!strap_loaded_reg)
        begin
            spike_detect_config_reg <= {threshold_strap_pin, duration_strap_pin};
            strap_loaded_reg        <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Measurement results
    // ------------------------------------------------------------------
    // Each result is one register, but its two bytes are read separately, so an update between the reads mixes them.
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            shunt_voltage_reg  <= {SDR_RESULT_RESET, 4'h0};
            supply_voltage_reg <= 11'h000;
        end
        else
        begin
            if (meas.sense_valid)
                shunt_voltage_reg <= meas.sense_code;
            if (meas.supply_valid)
                supply_voltage_reg <= meas.supply_code[11] ? 11'h000
                                    : meas.supply_code[10:0];
        end
    end

    // ------------------------------------------------------------------
    // Register reads
    // ------------------------------------------------------------------
    // Unmapped addresses read zero.
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            rdata  <= 8'h00;
            rvalid <= 1'b0;
        end
        else
        begin
            rvalid <= req.rd;
            case (req.addr)
                SDR_SPIKE_CFG_ADDR: rdata <= spike_detect_config_reg;
                SDR_SENSE_HI_ADDR:  rdata <= shunt_voltage_reg[11:4];
                SDR_SENSE_LO_ADDR:  rdata <= {shunt_voltage_reg[3:0], 4'h0};
                SDR_SUPPLY_HI_ADDR: rdata <= supply_voltage_reg[10:3];
                SDR_SUPPLY_LO_ADDR: rdata <= {supply_voltage_reg[2:0], 5'h00};
                default:            rdata <= 8'h00;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Threshold compare on the live sense code
    // ------------------------------------------------------------------
    // Threshold in codes: mV * 2047 / full scale, full scale doubling per range step.
    always_comb
    begin
        magnitude   = shunt_voltage_live[11] ? 12'(~shunt_voltage_live + 12'h001)
                                             : shunt_voltage_live;
        thresh_code = ((SDR_TH_BASE_UV + SDR_TH_STEP_UV * 32'(spike_threshold_code))
                      * SDR_SENSE_FS_CODE)
                      / (SDR_FS_BASE_UV << shunt_full_scale_sel);
        above       = 32'(magnitude) >= thresh_code;
    end

    // Duration in 10.24 us ticks; code 0 is a plain 1 ms count instead.
    always_comb
    begin
        case (spike_duration_code)
            4'h1:    dur_ticks = 32'd500;
            4'h2:    dur_ticks = 32'd2500;
            4'h3:    dur_ticks = 32'd5000;
            4'h4:    dur_ticks = 32'd7500;
            4'h5:    dur_ticks = 32'd10000;
            4'h6:    dur_ticks = 32'd12500;
            4'h7:    dur_ticks = 32'd25000;
            4'h8:    dur_ticks = 32'd37500;
            4'h9:    dur_ticks = 32'd50000;
            4'ha:    dur_ticks = 32'd75000;
            4'hb:    dur_ticks = 32'd100000;
            4'hc:    dur_ticks = 32'd150000;
            4'hd:    dur_ticks = 32'd200000;
            4'he:    dur_ticks = 32'd300000;
            4'hf:    dur_ticks = 32'd400000;
            default: dur_ticks = 32'd0;
        endcase
    end

    // ------------------------------------------------------------------
    // Spike detector
    // ------------------------------------------------------------------
    // Times a continuous excursion; any dip below threshold restarts it.
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            state_reg      <= SDR_IDLE;
            tick_cnt_reg   <= 32'd0;
            tick_total_reg <= 32'd0;
            ms_cnt_reg     <= 32'd0;
            ms_done_reg    <= 1'b0;
        end
        else
        begin
            case (state_reg)
                SDR_IDLE:
                begin
                    tick_cnt_reg   <= 32'd0;
                    tick_total_reg <= 32'd0;
                    ms_cnt_reg     <= 32'd0;
                    ms_done_reg    <= 1'b0;
                    if (above)
                        state_reg <= SDR_TIME;
                end
                SDR_TIME:
                begin
                    if (!above)
                        state_reg <= SDR_IDLE;
                    else
                    begin
                        if (ms_cnt_reg >= 32'(MS_CYCLES) - 32'd2)
                            ms_done_reg <= 1'b1;
                        else
                            ms_cnt_reg <= ms_cnt_reg + 32'd1;
                        if (tick_cnt_reg >= 32'(TICK_CYCLES) - 32'd1)
                        begin
                            tick_cnt_reg   <= 32'd0;
                            tick_total_reg <= tick_total_reg + 32'd1;
                        end
                        else
                            tick_cnt_reg <= tick_cnt_reg + 32'd1;
                        if ((spike_duration_code == 4'h0) ? ms_done_reg
                            : (tick_total_reg >= dur_ticks))
                            state_reg <= SDR_FIRED;
                    end
                end
                SDR_FIRED:
                begin
                    if (!above)
                        state_reg <= SDR_IDLE;
                end
                default: state_reg <= SDR_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Output routing
    // ------------------------------------------------------------------
    // The spike level goes to exactly one of the two outputs.
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            spike_alert_out    <= 1'b0;
            critical_alarm_out <= 1'b0;
        end
        else
        begin
            spike_alert_out    <= (state_reg == SDR_FIRED) && !spike_output_route;
            critical_alarm_out <= (state_reg == SDR_FIRED) && spike_output_route;
        end
    end

endmodule : sdr_spike_readout

/* sdr_props.sv */
/* Checker for the spike readout block, bound to every sdr_spike_readout.
   Assumes it sees only that module's ports and its one clock domain. */
`timescale 1ns/1ps
module sdr_props
    import sdr_pkg::*;
#(
    parameter int TICK_CYCLES = SDR_TICK_CYCLES,
    parameter int MS_CYCLES   = SDR_ONE_MS_CYCLES
)
(
    input wire logic        clk,
    input wire logic        rstn,
    input wire sdr_req_t    req,
    input wire logic [7:0]  rdata,
    input wire logic        rvalid,
    input wire logic [3:0]  threshold_strap_pin,
    input wire logic [3:0]  duration_strap_pin,
    input wire logic [1:0]  shunt_full_scale_sel,
    input wire logic        spike_output_route,
    input wire sdr_meas_t   meas,
    input wire logic [11:0] shunt_voltage_live,
    input wire logic        spike_alert_out,
    input wire logic        critical_alarm_out
);
    // ----------------------------------------------------------
    // Shadow results
    // ----------------------------------------------------------
    logic [11:0] sense_q;
    logic [10:0] sup_q;

    // Tracks the last stored results; negative supply reads as zero.
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            sense_q <= '0;
            sup_q   <= '0;
        end
        else
        begin
            if (meas.sense_valid)
                sense_q <= meas.sense_code;
            if (meas.supply_valid)
                sup_q <= meas.supply_code[11] ? 11'h000 : meas.supply_code[10:0];
        end
    end

    // ----------------------------------------------------------
    // Properties
    // ----------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    chk_rvalid_follows_rd: assert property (req.rd |=> rvalid)
        else $error("rvalid missing after read");
    chk_no_stray_rvalid: assert property (rvalid |-> $past(req.rd))
        else $error("rvalid without read");
    chk_cfg_write_read: assert property (req.wr && req.addr == SDR_SPIKE_CFG_ADDR ##1 !req.wr
        ##1 req.rd && req.addr == SDR_SPIKE_CFG_ADDR |=> rdata == $past(req.wdata, 3))
        else $error("config readback wrong");
    chk_sense_high_byte: assert property (req.rd && req.addr == SDR_SENSE_HI_ADDR
        |=> rdata == $past(sense_q[11:4])) else $error("sense high byte wrong");
    chk_sense_low_byte: assert property (req.rd && req.addr == SDR_SENSE_LO_ADDR
        |=> rdata == {$past(sense_q[3:0]), 4'h0}) else $error("sense low byte wrong");
    chk_supply_high_byte: assert property (req.rd && req.addr == SDR_SUPPLY_HI_ADDR
        |=> rdata == $past(sup_q[10:3])) else $error("supply high byte wrong");
    chk_supply_low_byte: assert property (req.rd && req.addr == SDR_SUPPLY_LO_ADDR
        |=> rdata == {$past(sup_q[2:0]), 5'h00}) else $error("supply low byte wrong");
    chk_quiet_when_zero: assert property ((shunt_voltage_live == 12'h000)[*3]
        |-> !spike_alert_out && !critical_alarm_out) else $error("spike with no input");
    chk_route_critical: assert property (critical_alarm_out |-> $past(spike_output_route))
        else $error("critical output on alert route");
    chk_route_alert: assert property (spike_alert_out |-> !$past(spike_output_route))
        else $error("alert output on critical route");

    // Main scenarios reached.
    cover property (critical_alarm_out);
    cover property (spike_alert_out);
    cover property (req.wr && req.addr == SDR_SPIKE_CFG_ADDR);
endmodule : sdr_props

bind sdr_spike_readout sdr_props #(
    .TICK_CYCLES(TICK_CYCLES),
    .MS_CYCLES  (MS_CYCLES)
) i_sdr_props (
    .clk                  (clk),
    .rstn                 (rstn),
    .req                  (req),
    .rdata                (rdata),
    .rvalid               (rvalid),
    .threshold_strap_pin  (threshold_strap_pin),
    .duration_strap_pin   (duration_strap_pin),
    .shunt_full_scale_sel (shunt_full_scale_sel),
    .spike_output_route   (spike_output_route),
    .meas                 (meas),
    .shunt_voltage_live   (shunt_voltage_live),
    .spike_alert_out      (spike_alert_out),
    .critical_alarm_out   (critical_alarm_out)
);

/* sdr_host_model.sv */
/* Host model issuing register reads and writes on the block's port.
   Assumes the caller shares the block's clock and uses its tasks. */
`timescale 1ns/1ps
module sdr_host_model
    import sdr_pkg::*;
(
    input  wire logic       clk,
    output sdr_req_t        req,
    input  wire logic [7:0] rdata,
    input  wire logic       rvalid
);
    // Bus idle at time zero.
    initial req = '0;

    // One-cycle write strobe; released data is inverted, not held.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        req <= '{1'b1, 1'b0, a, d};
        @(posedge clk);
        req.wr    <= 1'b0;
        req.wdata <= ~d;
    endtask : wr

    // One-cycle read strobe; data is taken while rvalid stands.
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        req <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge clk);
        req.rd <= 1'b0;
        #1;
        d = rvalid ? rdata : 8'hxx;
    endtask : rd
endmodule : sdr_host_model

/* tb_top.sv */
/* Self-checking testbench for the spike readout block.
   Assumes short tick counts so the tested durations (codes 0 to 2) run in a few thousand cycles. */
`timescale 1ns/1ps
module tb_top
    import sdr_pkg::*;
;
    logic        clk  = 1'b0;
    logic        rstn = 1'b0;
    sdr_req_t    req;
    logic [7:0]  rdata;
    logic        rvalid, alert, crit;
    logic        route = 1'b1;
    logic [1:0]  range = 2'h3;
    sdr_meas_t   meas  = '0;
    logic [11:0] live  = '0;
    logic [3:0]  th_strap  = 4'ha;
    logic [3:0]  dur_strap = 4'h5;
    int          num_errors  = 0;
    int          comparisons = 0;

    // Clock of 10 ns.
    always #5 clk = ~clk;

    sdr_spike_readout #(.TICK_CYCLES(2), .MS_CYCLES(10)) i_sdr_spike_readout (
        .clk(clk), .rstn(rstn), .req(req), .rdata(rdata), .rvalid(rvalid),
        .threshold_strap_pin(th_strap), .duration_strap_pin(dur_strap),
        .shunt_full_scale_sel(range), .spike_output_route(route), .meas(meas),
        .shunt_voltage_live(live), .spike_alert_out(alert), .critical_alarm_out(crit));
    sdr_host_model i_sdr_host_model (.clk(clk), .req(req), .rdata(rdata), .rvalid(rvalid));

    // ----------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------
    task automatic check(input logic [11:0] seen, input logic [11:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        i_sdr_host_model.rd(a, d);
        check({4'h0, d}, {4'h0, e});
    endtask : rdchk

    // Drives the live sense code and lets n cycles pass.
    task automatic hold(input logic [11:0] v, input int n);
        @(posedge clk);
        live <= v;
        repeat (n) @(posedge clk);
        #1;
    endtask : hold

    task automatic end_sim();
        $display("Comparisons %0d, errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : end_sim

    // ----------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------
    task automatic t_regs();
        rdchk(SDR_SPIKE_CFG_ADDR, 8'ha5);
        rdchk(SDR_SENSE_HI_ADDR, SDR_RESULT_RESET);
        rdchk(SDR_SUPPLY_LO_ADDR, SDR_RESULT_RESET);
        i_sdr_host_model.wr(SDR_SENSE_HI_ADDR, 8'h5a);
        rdchk(SDR_SENSE_HI_ADDR, 8'h00);
        rdchk(8'h53, 8'h00);
        i_sdr_host_model.wr(SDR_SPIKE_CFG_ADDR, 8'h3c);
        rdchk(SDR_SPIKE_CFG_ADDR, 8'h3c);
        $display("t_regs done");
    endtask : t_regs

    task automatic t_meas();
        logic [11:0] s [4] = '{12'h800, 12'h7ff, 12'hffe, 12'h001};
        logic [11:0] v [4] = '{12'h273, 12'h9ff, 12'h7ff, 12'h001};
        logic [10:0] m;
        foreach (s[i])
        begin
            @(posedge clk);
            meas <= '{1'b1, s[i], 1'b1, v[i]};
            @(posedge clk);
            meas <= '0;
            m = v[i][11] ? 11'h000 : v[i][10:0];
            rdchk(SDR_SENSE_HI_ADDR, s[i][11:4]);
            rdchk(SDR_SENSE_LO_ADDR, {s[i][3:0], 4'h0});
            rdchk(SDR_SUPPLY_HI_ADDR, m[10:3]);
            rdchk(SDR_SUPPLY_LO_ADDR, {m[2:0], 5'h00});
        end
        $display("t_meas done");
    endtask : t_meas

    // Mid-run reset with new straps: straps reload, stored results clear.
    task automatic t_reset();
        @(posedge clk);
        th_strap  <= 4'h6;
        dur_strap <= 4'h3;
        rstn      <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        rdchk(SDR_SPIKE_CFG_ADDR, 8'h63);
        rdchk(SDR_SENSE_LO_ADDR, SDR_RESULT_RESET);
        rdchk(SDR_SUPPLY_LO_ADDR, SDR_RESULT_RESET);
        $display("t_reset done");
    endtask : t_reset

    task automatic t_spike();
        i_sdr_host_model.wr(SDR_SPIKE_CFG_ADDR, 8'h00);
        hold(12'd300, 5);
        check(crit, 1'b0);
        hold(12'hed4, 30);
        check(crit, 1'b1);
        route <= 1'b0;
        hold(12'hed4, 3);
        check(alert, 1'b1);
        route <= 1'b1;
        hold(12'd0, 4);
        check(crit, 1'b0);
        i_sdr_host_model.wr(SDR_SPIKE_CFG_ADDR, 8'h10);
        hold(12'd300, 30);
        check(crit, 1'b0);
        hold(12'd400, 30);
        check(crit, 1'b1);
        i_sdr_host_model.wr(SDR_SPIKE_CFG_ADDR, 8'h00);
        rdchk(SDR_SPIKE_CFG_ADDR, 8'h00);
        check(crit, 1'b1);
        range <= 2'h0;
        hold(12'd0, 4);
        hold(12'd400, 30);
        check(crit, 1'b0);
        range <= 2'h2;
        hold(12'd400, 30);
        check(crit, 1'b0);
        hold(12'd600, 30);
        check(crit, 1'b1);
        range <= 2'h3;
        i_sdr_host_model.wr(SDR_SPIKE_CFG_ADDR, 8'h01);
        hold(12'd0, 4);
        hold(12'd400, 900);
        check(crit, 1'b0);
        repeat (200) @(posedge clk);
        #1;
        check(crit, 1'b1);
        i_sdr_host_model.wr(SDR_SPIKE_CFG_ADDR, 8'h02);
        hold(12'd0, 4);
        hold(12'd400, 4900);
        check(crit, 1'b0);
        repeat (200) @(posedge clk);
        #1;
        check(crit, 1'b1);
        $display("t_spike done");
    endtask : t_spike

    // Main sequence: reset for six cycles, then each scenario.
    initial
    begin
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        t_regs();
        t_meas();
        t_reset();
        t_spike();
        end_sim();
    end

    // Watchdog against a hung run.
    initial
    begin
        repeat (20000) @(posedge clk);
        num_errors++;
        end_sim();
    end
endmodule : tb_top
